// ### rtl/uepl_led.sv
module uepl_led (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic corrupt_in,
  input wire logic flash_in,
  input wire logic fail_in,
  output logic led_out
);

  uepl_pkg::uepl_led_e mode_q;
  uepl_pkg::uepl_led_e mode_d;
  uepl_pkg::uepl_led_e want;
  logic [uepl_pkg::PH_W-1:0] ph_q;
  logic [uepl_pkg::PH_W-1:0] ph_d;
  logic [uepl_pkg::MS_W-1:0] ms_q;
  logic [uepl_pkg::MS_W-1:0] ms_d;
  logic led_q;
  logic led_d;

  // Steady states fold into the pattern that leads to them
  function automatic uepl_pkg::uepl_led_e group(uepl_pkg::uepl_led_e m);
    case (m)
      uepl_pkg::M_ON: group = uepl_pkg::M_BOOT;
      uepl_pkg::M_OFF: group = uepl_pkg::M_FAIL;
      default: group = m;
    endcase
  endfunction

  function automatic logic [uepl_pkg::MS_W-1:0] half_len(
    uepl_pkg::uepl_led_e m, logic [uepl_pkg::PH_W-1:0] p);
    case (m)
      uepl_pkg::M_BOOT: half_len = uepl_pkg::BOOT_HALF_MS;
      uepl_pkg::M_FLASH: half_len = uepl_pkg::FLASH_HALF_MS;
      uepl_pkg::M_CORRUPT: half_len = (p < uepl_pkg::CORRUPT_PHASES) ?
        uepl_pkg::CORRUPT_HALF_MS : uepl_pkg::CORRUPT_PAUSE_MS;
      default: half_len = uepl_pkg::FAIL_HALF_MS;
    endcase
  endfunction

  function automatic logic lit(uepl_pkg::uepl_led_e m,
    logic [uepl_pkg::PH_W-1:0] p);
    case (m)
      uepl_pkg::M_ON: lit = 1'b1;
      uepl_pkg::M_CORRUPT: lit = (p < uepl_pkg::CORRUPT_PHASES) && !p[0];
      uepl_pkg::M_OFF: lit = 1'b0;
      default: lit = !p[0];
    endcase
  endfunction

  // ****************************************************************
  // Pattern sequencer
  // ****************************************************************
  always_comb
  begin
    mode_d = mode_q;
    ph_d = ph_q;
    ms_d = ms_q;
    if (corrupt_in)
      want = uepl_pkg::M_CORRUPT;
    else if (flash_in)
      want = uepl_pkg::M_FLASH;
    else if (fail_in)
      want = uepl_pkg::M_FAIL;
    else
      want = uepl_pkg::M_BOOT;
    if (want != group(mode_q))
    begin
      mode_d = want;
      ph_d = '0;
      ms_d = '0;
    end
    else if (tick_in && mode_q != uepl_pkg::M_ON &&
      mode_q != uepl_pkg::M_OFF)
    begin
      if (ms_q == half_len(mode_q, ph_q) - 1'b1)
      begin
        ms_d = '0;
        ph_d = ph_q + 1'b1;
        case (mode_q)
          uepl_pkg::M_BOOT:
          begin
            if (ph_q == uepl_pkg::BOOT_PHASES - 1'b1)
            begin
              mode_d = uepl_pkg::M_ON;
              ph_d = '0;
            end
          end
          uepl_pkg::M_FLASH:
          begin
            if (ph_q == uepl_pkg::FLASH_PHASES - 1'b1)
              ph_d = '0;
          end
          uepl_pkg::M_CORRUPT:
          begin
            if (ph_q == uepl_pkg::CORRUPT_PHASES)
              ph_d = '0;
          end
          default:
          begin
            if (ph_q == uepl_pkg::FAIL_PHASES - 1'b1)
            begin
              mode_d = uepl_pkg::M_OFF;
              ph_d = '0;
            end
          end
        endcase
      end
      else
        ms_d = ms_q + 1'b1;
    end
    led_d = lit(mode_d, ph_d);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      mode_q <= uepl_pkg::M_BOOT;
      ph_q <= '0;
      ms_q <= '0;
      led_q <= 1'b1;
    end
    else
    begin
      mode_q <= mode_d;
      ph_q <= ph_d;
      ms_q <= ms_d;
      led_q <= led_d;
    end
  end

  assign led_out = led_q;

  property p_on_solid;
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_q == uepl_pkg::M_ON) [*2] |-> led_q && $stable(led_q);
  endproperty
  a_on_solid: assert property (p_on_solid)
    else $error("LED not solid after power-up blinks");

  property p_blink_on_tick;
    @(posedge clk_in) disable iff (!rst_n_in)
    ($changed(led_q) && $stable(mode_q) && mode_q == uepl_pkg::M_FLASH)
      |-> $past(tick_in);
  endproperty
  a_blink_on_tick: assert property (p_blink_on_tick)
    else $error("Flash blink changed without a tick");

  property p_corrupt_pause;
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_q == uepl_pkg::M_CORRUPT && ph_q == uepl_pkg::CORRUPT_PHASES)
      |-> !led_q;
  endproperty
  a_corrupt_pause: assert property (p_corrupt_pause)
    else $error("LED lit during corruption pause");

  property p_fail_off;
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_q == uepl_pkg::M_OFF && fail_in && !flash_in && !corrupt_in)
      |=> !led_q;
  endproperty
  a_fail_off: assert property (p_fail_off)
    else $error("LED not off after failed enumeration");

  property p_restart;
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> mode_q == uepl_pkg::M_BOOT && ph_q == '0 && led_q;
  endproperty
  a_restart: assert property (p_restart)
    else $error("Power-up pattern not restarted by reset");

endmodule

// ### rtl/uepl_pkg.sv
package uepl_pkg;

  // ****************************************************************
  // Endpoint addresses and packet size
  // ****************************************************************
  localparam logic [7:0] EP0_OUT_ADDR = 8'h00;
  localparam logic [7:0] EP0_IN_ADDR = 8'h80;
  localparam logic [7:0] EP1_OUT_ADDR = 8'h01;
  localparam logic [7:0] EP2_IN_ADDR = 8'h82;
  localparam logic [7:0] EP3_OUT_ADDR = 8'h03;
  localparam logic [7:0] EP3_IN_ADDR = 8'h83;
  localparam int EP_DIR_BIT = 7;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] MAX_PKT = 7'h40;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_INT =
    (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCNT_W = 8;
  localparam logic [SCNT_W-1:0] STRAP_SETTLE_CYC =
    SCNT_W'(STRAP_SETTLE_INT);

  // ****************************************************************
  // LED patterns, times in milliseconds
  // ****************************************************************
  localparam int MS_W = 10;
  localparam int PH_W = 4;
  localparam int BOOT_TOTAL_MS = 2000;
  localparam int BOOT_BLINKS = 6;
  localparam int FLASH_RATE_HZ = 4;
  localparam int CORRUPT_BLINKS = 3;
  localparam int FAIL_BLINKS = 5;
  localparam logic [MS_W-1:0] BOOT_HALF_MS =
    MS_W'(BOOT_TOTAL_MS / (2 * BOOT_BLINKS));
  localparam logic [MS_W-1:0] FLASH_HALF_MS =
    MS_W'(1000 / (2 * FLASH_RATE_HZ));
  localparam logic [MS_W-1:0] CORRUPT_HALF_MS = 10'h096;
  localparam logic [MS_W-1:0] CORRUPT_PAUSE_MS = 10'h3E8;
  localparam logic [MS_W-1:0] FAIL_HALF_MS = 10'h064;
  localparam logic [PH_W-1:0] BOOT_PHASES = PH_W'(2 * BOOT_BLINKS);
  localparam logic [PH_W-1:0] FLASH_PHASES = 4'h2;
  localparam logic [PH_W-1:0] CORRUPT_PHASES = PH_W'(2 * CORRUPT_BLINKS);
  localparam logic [PH_W-1:0] FAIL_PHASES = PH_W'(2 * FAIL_BLINKS);

  typedef enum logic [2:0] {
    M_BOOT, M_ON, M_FLASH, M_CORRUPT, M_FAIL, M_OFF
  } uepl_led_e;

  // ****************************************************************
  // Start-up mode codes
  // ****************************************************************
  localparam logic [1:0] START_NONE = 2'h0;
  localparam logic [1:0] START_APP = 2'h1;
  localparam logic [1:0] START_FLASH = 2'h2;

endpackage

// ### rtl/uepl_tick.sv
module uepl_tick #(
  parameter int DIV = 100000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic tick_out
);

  localparam int W = (DIV > 2) ? $clog2(DIV) : 1;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  always_comb
  begin
    if (cnt_q == W'(DIV - 1))
    begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + 1'b1;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;

  property p_tick_gap;
    @(posedge clk_in) disable iff (!rst_n_in)
    tick_q |=> !tick_q;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("Prescaler tick lasted two cycles");

endmodule

// ### rtl/uepl_top.sv
module uepl_top #(
  parameter int TICK_DIV = uepl_pkg::TICK_CYCLES
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic SIE_TOK_VALID_IN,
  input wire logic [7:0] SIE_TOK_ADDR_IN,
  input wire logic SIE_RX_VALID_IN,
  input wire logic [7:0] SIE_RX_DATA_IN,
  input wire logic SIE_RX_LAST_IN,
  input wire logic SIE_TX_READY_IN,
  output logic SIE_TX_VALID_OUT,
  output logic [7:0] SIE_TX_DATA_OUT,
  output logic SIE_TX_LAST_OUT,
  output logic SIE_STALL_OUT,
  output logic SIE_NAK_OUT,
  output logic SIE_OVERSIZE_OUT,
  output logic CTRL_RX_VALID_OUT,
  output logic [7:0] CTRL_RX_DATA_OUT,
  output logic CTRL_RX_LAST_OUT,
  input wire logic CTRL_TX_VALID_IN,
  input wire logic [7:0] CTRL_TX_DATA_IN,
  input wire logic CTRL_TX_LAST_IN,
  output logic CTRL_TX_READY_OUT,
  output logic CMD_VALID_OUT,
  output logic [7:0] CMD_DATA_OUT,
  output logic CMD_LAST_OUT,
  input wire logic RSP_VALID_IN,
  input wire logic [7:0] RSP_DATA_IN,
  input wire logic RSP_LAST_IN,
  output logic RSP_READY_OUT,
  input wire logic STRM_VALID_IN,
  input wire logic [7:0] STRM_DATA_IN,
  output logic STRM_READY_OUT,
  input wire logic FLASH_MODE_IN,
  input wire logic MEM_CORRUPT_IN,
  input wire logic ENUM_FAIL_IN,
  output logic STATUS_LED_OUT,
  input wire logic SPECIAL_STRAP_PIN_IN,
  output logic FLEX_LINE_FOUR_OUT,
  output logic FLEX_LINE_FOUR_OE_OUT,
  output logic FLEX_LINE_FIVE_OUT,
  output logic FLEX_LINE_FIVE_OE_OUT,
  output logic [1:0] START_MODE_OUT,
  output logic STRAP_DONE_OUT
);

  typedef enum logic [2:0] {
    R_IDLE, R_OUT0, R_OUT1, R_DROP, R_IN0, R_IN2, R_IN3
  } uepl_route_e;

  typedef enum logic [1:0] {S_DRV_FOUR, S_DRV_FIVE, S_DONE} uepl_strap_e;

  uepl_route_e st_q, st_d;
  logic [uepl_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic tx_valid_q, tx_valid_d, tx_last_q, tx_last_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic stall_q, stall_d, nak_q, nak_d, ovf_q, ovf_d;
  logic ctrl_rdy_q, ctrl_rdy_d, rsp_rdy_q, rsp_rdy_d;
  logic strm_rdy_q, strm_rdy_d;
  logic cmd_valid_q, cmd_valid_d, cmd_last_q, cmd_last_d;
  logic [7:0] cmd_data_q, cmd_data_d;
  logic crx_valid_q, crx_valid_d, crx_last_q, crx_last_d;
  logic [7:0] crx_data_q, crx_data_d;
  logic take;
  logic [7:0] src_data;
  logic src_last;

  // ****************************************************************
  // Endpoint router
  // ****************************************************************
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    tx_valid_d = tx_valid_q;
    tx_data_d = tx_data_q;
    tx_last_d = tx_last_q;
    stall_d = 1'b0;
    nak_d = 1'b0;
    ovf_d = 1'b0;
    cmd_valid_d = 1'b0;
    cmd_data_d = cmd_data_q;
    cmd_last_d = cmd_last_q;
    crx_valid_d = 1'b0;
    crx_data_d = crx_data_q;
    crx_last_d = crx_last_q;
    take = 1'b0;
    src_data = STRM_DATA_IN;
    src_last = 1'b0;
    case (st_q)
      R_IN0:
      begin
        take = ctrl_rdy_q && CTRL_TX_VALID_IN;
        src_data = CTRL_TX_DATA_IN;
        src_last = CTRL_TX_LAST_IN;
      end
      R_IN2:
      begin
        take = rsp_rdy_q && RSP_VALID_IN;
        src_data = RSP_DATA_IN;
        src_last = RSP_LAST_IN;
      end
      R_IN3:
        take = strm_rdy_q && STRM_VALID_IN;
      default:
        take = 1'b0;
    endcase
    if (tx_valid_q && SIE_TX_READY_IN)
    begin
      tx_valid_d = 1'b0;
      if (tx_last_q)
        st_d = R_IDLE;
    end
    case (st_q)
      R_IDLE:
      begin
        if (SIE_TOK_VALID_IN)
        begin
          cnt_d = '0;
          case (SIE_TOK_ADDR_IN)
            uepl_pkg::EP0_OUT_ADDR: st_d = R_OUT0;
            uepl_pkg::EP1_OUT_ADDR: st_d = R_OUT1;
            uepl_pkg::EP0_IN_ADDR:
            begin
              if (CTRL_TX_VALID_IN)
                st_d = R_IN0;
              else
                nak_d = 1'b1;
            end
            uepl_pkg::EP2_IN_ADDR:
            begin
              if (RSP_VALID_IN)
                st_d = R_IN2;
              else
                nak_d = 1'b1;
            end
            uepl_pkg::EP3_IN_ADDR:
            begin
              if (STRM_VALID_IN)
                st_d = R_IN3;
              else
                nak_d = 1'b1;
            end
            default:
            begin
              // Dummy endpoint three OUT and unknown endpoints
              stall_d = 1'b1;
              if (!SIE_TOK_ADDR_IN[uepl_pkg::EP_DIR_BIT])
                st_d = R_DROP;
            end
          endcase
        end
      end
      R_OUT0, R_OUT1, R_DROP:
      begin
        if (SIE_RX_VALID_IN)
        begin
          if (st_q != R_DROP && cnt_q == uepl_pkg::MAX_PKT)
            ovf_d = 1'b1;
          else if (st_q == R_OUT1)
          begin
            cmd_valid_d = 1'b1;
            cmd_data_d = SIE_RX_DATA_IN;
            cmd_last_d = SIE_RX_LAST_IN;
            cnt_d = cnt_q + 1'b1;
          end
          else if (st_q == R_OUT0)
          begin
            crx_valid_d = 1'b1;
            crx_data_d = SIE_RX_DATA_IN;
            crx_last_d = SIE_RX_LAST_IN;
            cnt_d = cnt_q + 1'b1;
          end
          if (SIE_RX_LAST_IN)
            st_d = R_IDLE;
        end
      end
      R_IN0, R_IN2, R_IN3:
      begin
        if (take)
        begin
          tx_valid_d = 1'b1;
          tx_data_d = src_data;
          tx_last_d = src_last ||
            (cnt_q == uepl_pkg::MAX_PKT - 1'b1);
          cnt_d = cnt_q + 1'b1;
        end
      end
      default:
        st_d = R_IDLE;
    endcase
    ctrl_rdy_d = (st_d == R_IN0) && !tx_valid_d;
    rsp_rdy_d = (st_d == R_IN2) && !tx_valid_d;
    strm_rdy_d = (st_d == R_IN3) && !tx_valid_d;
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      st_q <= R_IDLE;
      cnt_q <= '0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
      stall_q <= 1'b0;
      nak_q <= 1'b0;
      ovf_q <= 1'b0;
      ctrl_rdy_q <= 1'b0;
      rsp_rdy_q <= 1'b0;
      strm_rdy_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_data_q <= 8'h00;
      cmd_last_q <= 1'b0;
      crx_valid_q <= 1'b0;
      crx_data_q <= 8'h00;
      crx_last_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tx_valid_q <= tx_valid_d;
      tx_data_q <= tx_data_d;
      tx_last_q <= tx_last_d;
      stall_q <= stall_d;
      nak_q <= nak_d;
      ovf_q <= ovf_d;
      ctrl_rdy_q <= ctrl_rdy_d;
      rsp_rdy_q <= rsp_rdy_d;
      strm_rdy_q <= strm_rdy_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_data_q <= cmd_data_d;
      cmd_last_q <= cmd_last_d;
      crx_valid_q <= crx_valid_d;
      crx_data_q <= crx_data_d;
      crx_last_q <= crx_last_d;
    end
  end

  assign SIE_TX_VALID_OUT = tx_valid_q;
  assign SIE_TX_DATA_OUT = tx_data_q;
  assign SIE_TX_LAST_OUT = tx_last_q;
  assign SIE_STALL_OUT = stall_q;
  assign SIE_NAK_OUT = nak_q;
  assign SIE_OVERSIZE_OUT = ovf_q;
  assign CTRL_TX_READY_OUT = ctrl_rdy_q;
  assign RSP_READY_OUT = rsp_rdy_q;
  assign STRM_READY_OUT = strm_rdy_q;
  assign CMD_VALID_OUT = cmd_valid_q;
  assign CMD_DATA_OUT = cmd_data_q;
  assign CMD_LAST_OUT = cmd_last_q;
  assign CTRL_RX_VALID_OUT = crx_valid_q;
  assign CTRL_RX_DATA_OUT = crx_data_q;
  assign CTRL_RX_LAST_OUT = crx_last_q;

  // ****************************************************************
  // Recovery strap detection
  // ****************************************************************
  uepl_strap_e sst_q, sst_d;
  logic [uepl_pkg::SCNT_W-1:0] scnt_q, scnt_d;
  logic seen_q, seen_d, four_q, four_d, five_q, five_d, oe_q, oe_d;
  logic done_q, done_d;
  logic [1:0] smode_q, smode_d;

  always_comb
  begin
    sst_d = sst_q;
    scnt_d = scnt_q + 1'b1;
    seen_d = seen_q;
    four_d = four_q;
    five_d = five_q;
    oe_d = oe_q;
    done_d = done_q;
    smode_d = smode_q;
    case (sst_q)
      S_DRV_FOUR:
      begin
        if (scnt_q == uepl_pkg::STRAP_SETTLE_CYC - 1'b1)
        begin
          seen_d = SPECIAL_STRAP_PIN_IN;
          scnt_d = '0;
          four_d = 1'b0;
          five_d = 1'b1;
          sst_d = S_DRV_FIVE;
        end
      end
      S_DRV_FIVE:
      begin
        if (scnt_q == uepl_pkg::STRAP_SETTLE_CYC - 1'b1)
        begin
          if (seen_q && !SPECIAL_STRAP_PIN_IN)
            smode_d = uepl_pkg::START_APP;
          else if (!seen_q && SPECIAL_STRAP_PIN_IN)
            smode_d = uepl_pkg::START_FLASH;
          else
            smode_d = uepl_pkg::START_NONE;
          scnt_d = '0;
          five_d = 1'b0;
          oe_d = 1'b0;
          done_d = 1'b1;
          sst_d = S_DONE;
        end
      end
      default:
        scnt_d = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      sst_q <= S_DRV_FOUR;
      scnt_q <= '0;
      seen_q <= 1'b0;
      four_q <= 1'b1;
      five_q <= 1'b0;
      oe_q <= 1'b1;
      done_q <= 1'b0;
      smode_q <= uepl_pkg::START_NONE;
    end
    else
    begin
      sst_q <= sst_d;
      scnt_q <= scnt_d;
      seen_q <= seen_d;
      four_q <= four_d;
      five_q <= five_d;
      oe_q <= oe_d;
      done_q <= done_d;
      smode_q <= smode_d;
    end
  end

  assign FLEX_LINE_FOUR_OUT = four_q;
  assign FLEX_LINE_FIVE_OUT = five_q;
  assign FLEX_LINE_FOUR_OE_OUT = oe_q;
  assign FLEX_LINE_FIVE_OE_OUT = oe_q;
  assign START_MODE_OUT = smode_q;
  assign STRAP_DONE_OUT = done_q;

  // ****************************************************************
  // Status LED
  // ****************************************************************
  logic tick;

  uepl_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .tick_out(tick)
  );

  uepl_led u_led (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .tick_in(tick),
    .corrupt_in(MEM_CORRUPT_IN),
    .flash_in(FLASH_MODE_IN),
    .fail_in(ENUM_FAIL_IN),
    .led_out(STATUS_LED_OUT)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_ctrl_rx_src;
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    CTRL_RX_VALID_OUT |-> $past(st_q) == R_OUT0 && !CMD_VALID_OUT;
  endproperty
  a_ctrl_rx_src: assert property (p_ctrl_rx_src)
    else $error("Control data forwarded outside endpoint zero");

  property p_cmd_size;
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    CMD_VALID_OUT |-> $past(cnt_q) < uepl_pkg::MAX_PKT;
  endproperty
  a_cmd_size: assert property (p_cmd_size)
    else $error("Command byte beyond packet size forwarded");

  property p_in_size;
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (SIE_TX_VALID_OUT && cnt_q == uepl_pkg::MAX_PKT) |-> SIE_TX_LAST_OUT;
  endproperty
  a_in_size: assert property (p_in_size)
    else $error("IN packet ran past its size limit");

  property p_dummy_stall;
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (st_q == R_IDLE && SIE_TOK_VALID_IN &&
      SIE_TOK_ADDR_IN == uepl_pkg::EP3_OUT_ADDR)
      |=> SIE_STALL_OUT && st_q == R_DROP;
  endproperty
  a_dummy_stall: assert property (p_dummy_stall)
    else $error("Dummy OUT endpoint not refused");

  property p_cmd_path;
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    CMD_VALID_OUT |-> $past(st_q) == R_OUT1;
  endproperty
  a_cmd_path: assert property (p_cmd_path)
    else $error("Command taken from wrong endpoint");

  property p_stream_only;
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    STRM_READY_OUT |-> !RSP_READY_OUT && !CTRL_TX_READY_OUT &&
      st_q == R_IN3;
  endproperty
  a_stream_only: assert property (p_stream_only)
    else $error("Stream endpoint open to response data");

  property p_strap_hold;
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    $past(STRAP_DONE_OUT) |-> STRAP_DONE_OUT && $stable(START_MODE_OUT)
      && !FLEX_LINE_FOUR_OE_OUT;
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("Start-up mode changed after strap sensing");

  property p_strap_time;
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    $rose(FLEX_LINE_FIVE_OUT) |-> ##[1:300] STRAP_DONE_OUT;
  endproperty
  a_strap_time: assert property (p_strap_time)
    else $error("Strap sensing did not finish in time");

endmodule

// ### tb/uepl_host.sv
module uepl_host (
  input wire logic CORE_CLK_IN,
  input wire logic SIE_TX_VALID_OUT,
  output logic SIE_TOK_VALID_IN,
  output logic [7:0] SIE_TOK_ADDR_IN,
  output logic SIE_RX_VALID_IN,
  output logic [7:0] SIE_RX_DATA_IN,
  output logic SIE_RX_LAST_IN,
  output logic SIE_TX_READY_IN
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 32'hAD4A;
  initial
  begin
    {SIE_TOK_VALID_IN, SIE_RX_VALID_IN, SIE_RX_LAST_IN} = 3'h0;
    {SIE_TOK_ADDR_IN, SIE_RX_DATA_IN, SIE_TX_READY_IN} = 17'h00000;
  end
  // ****
  // Takes IN bytes promptly or late
  // ****
  always @(negedge CORE_CLK_IN)
    SIE_TX_READY_IN <= SIE_TX_VALID_OUT & 1'($random(seed));
  // Dummy OUT half is addressed only on purpose
  task automatic xfer(input logic [7:0] a, input int n, input logic [7:0] b);
    @(negedge CORE_CLK_IN);
    SIE_TOK_VALID_IN = 1'b1;
    SIE_TOK_ADDR_IN = a;
    @(negedge CORE_CLK_IN);
    SIE_TOK_VALID_IN = 1'b0;
    SIE_TOK_ADDR_IN = ~a;
    for (int i = 0; i < n; i++)
    begin
      SIE_RX_VALID_IN = 1'b1;
      SIE_RX_DATA_IN = b + i[7:0];
      SIE_RX_LAST_IN = (i == n - 1);
      @(negedge CORE_CLK_IN);
    end
    SIE_RX_VALID_IN = 1'b0;
    SIE_RX_LAST_IN = 1'b0;
    SIE_RX_DATA_IN = ~SIE_RX_DATA_IN;
  endtask
endmodule

// ### tb/uepl_tb_top.sv
module uepl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK_IN = 1'b0;
  logic RST_N_IN = 1'b0;
  logic SIE_TOK_VALID_IN, SIE_RX_VALID_IN, SIE_RX_LAST_IN, SIE_TX_READY_IN;
  logic [7:0] SIE_TOK_ADDR_IN, SIE_RX_DATA_IN, SIE_TX_DATA_OUT, CMD_DATA_OUT;
  logic [7:0] CTRL_RX_DATA_OUT, CTRL_TX_DATA_IN = 8'h00;
  logic [7:0] RSP_DATA_IN = 8'h00, STRM_DATA_IN = 8'h00;
  logic SIE_TX_VALID_OUT, SIE_TX_LAST_OUT, SIE_STALL_OUT, SIE_NAK_OUT;
  logic SIE_OVERSIZE_OUT, CTRL_RX_VALID_OUT, CTRL_RX_LAST_OUT;
  logic CTRL_TX_READY_OUT, CMD_VALID_OUT, CMD_LAST_OUT, RSP_READY_OUT;
  logic STRM_READY_OUT, STATUS_LED_OUT, FLEX_LINE_FOUR_OUT;
  logic FLEX_LINE_FOUR_OE_OUT, FLEX_LINE_FIVE_OUT, FLEX_LINE_FIVE_OE_OUT;
  logic STRAP_DONE_OUT;
  logic [1:0] START_MODE_OUT;
  logic CTRL_TX_VALID_IN = 1'b0, CTRL_TX_LAST_IN = 1'b0, RSP_VALID_IN = 1'b0;
  logic RSP_LAST_IN = 1'b0, STRM_VALID_IN = 1'b0, FLASH_MODE_IN = 1'b0;
  logic MEM_CORRUPT_IN = 1'b0, ENUM_FAIL_IN = 1'b0, SPECIAL_STRAP_PIN_IN = 1'b0;
  int n_mismatch = 0, checked = 0, n_stall = 0, n_nak = 0, n_ovs = 0;
  int seed = 32'hAD4A;
  logic jump_five = 1'b0;
  logic [9:0] q_rx [$];
  logic [8:0] q_tx [$];
  uepl_top #(.TICK_DIV(4)) dut (.*);
  uepl_host host (.*);
  initial
    forever #5 CORE_CLK_IN = ~CORE_CLK_IN;
  // Jumper ties the strap pin to line four, after second reset to five
  always @(negedge CORE_CLK_IN)
    SPECIAL_STRAP_PIN_IN <= jump_five ? FLEX_LINE_FIVE_OUT :
      FLEX_LINE_FOUR_OUT;
  // ****
  // Checking
  // ****
  task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] s);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  always @(posedge CORE_CLK_IN)
  begin
    n_stall += SIE_STALL_OUT;
    n_nak += SIE_NAK_OUT;
    n_ovs += SIE_OVERSIZE_OUT;
    if (CMD_VALID_OUT === 1'b1 || CTRL_RX_VALID_OUT === 1'b1)
      cmp("rx", q_rx.pop_front(), CMD_VALID_OUT === 1'b1 ?
        {2'b00, CMD_DATA_OUT} | {1'b0, CMD_LAST_OUT, 8'h00} :
        {1'b1, CTRL_RX_LAST_OUT, CTRL_RX_DATA_OUT});
    if (SIE_TX_VALID_OUT === 1'b1 && SIE_TX_READY_IN === 1'b1)
      cmp("tx", {1'b0, q_tx.pop_front()},
        {1'b0, SIE_TX_LAST_OUT, SIE_TX_DATA_OUT});
  end
  task automatic out(input logic [7:0] a, input int n, input logic [7:0] b);
    for (int i = 0; i < n && i < 64; i++)
      if (a == 8'h01 || a == 8'h00)
        q_rx.push_back({a == 8'h00, i == n - 1, b + i[7:0]});
    host.xfer(a, n, b);
  endtask
  // Source select: 0 control IN, 1 response, 2 stream
  task automatic src(input logic [1:0] s, input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++)
    begin
      {CTRL_TX_VALID_IN, RSP_VALID_IN, STRM_VALID_IN} = 3'h4 >> s;
      {CTRL_TX_LAST_IN, RSP_LAST_IN} = (i == n - 1) ? 2'h2 >> s : 2'h0;
      {CTRL_TX_DATA_IN, RSP_DATA_IN, STRM_DATA_IN} = {3{b + i[7:0]}};
      q_tx.push_back({i == n - 1, b + i[7:0]});
      do @(posedge CORE_CLK_IN);
      while (({CTRL_TX_READY_OUT, RSP_READY_OUT, STRM_READY_OUT} &
        (3'h4 >> s)) !== (3'h4 >> s));
      cmp("idle_ready", 10'h000, {7'h00, {CTRL_TX_READY_OUT,
        RSP_READY_OUT, STRM_READY_OUT} & ~(3'h4 >> s)});
      @(negedge CORE_CLK_IN);
    end
    {CTRL_TX_VALID_IN, RSP_VALID_IN, STRM_VALID_IN} = 3'h0;
    {CTRL_TX_LAST_IN, RSP_LAST_IN} = 2'h0;
    {RSP_DATA_IN, STRM_DATA_IN} = ~{RSP_DATA_IN, STRM_DATA_IN};
    for (int k = 0; k < 200 && q_tx.size() > 0; k++)
      @(negedge CORE_CLK_IN);
  endtask
  task automatic led_chk();
    logic [2:0] md [4] = '{3'h0, 3'h2, 3'h6, 3'h1};
    int win [4] = '{8400, 2100, 7800, 4500};
    logic [9:0] want [4] = '{10'h20C, 10'h204, 10'h206, 10'h009};
    int t;
    logic p;
    for (int m = 0; m < 4; m++)
    begin
      {MEM_CORRUPT_IN, FLASH_MODE_IN, ENUM_FAIL_IN} = md[m];
      t = 0;
      p = STATUS_LED_OUT;
      repeat (win[m])
      begin
        @(negedge CORE_CLK_IN);
        t += (STATUS_LED_OUT !== p);
        p = STATUS_LED_OUT;
      end
      cmp("led", want[m], {STATUS_LED_OUT, t[8:0]});
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge CORE_CLK_IN);
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    repeat (8) @(negedge CORE_CLK_IN);
    RST_N_IN = 1'b1;
    fork
      led_chk();
      begin
        out(8'h01, 2, 8'($random(seed)));
        out(8'h01, 65, 8'($random(seed)));
        out(8'h00, 3, 8'hF0);
        out(8'h03, 4, 8'h33);
        out(8'h82, 0, 8'h00);
        fork
          src(2'h1, 3, 8'hA0);
          out(8'h82, 0, 8'h00);
        join
        fork
          src(2'h2, 64, 8'($random(seed)));
          out(8'h83, 0, 8'h00);
        join
        out(8'h80, 0, 8'h00);
        out(8'h81, 0, 8'h00);
        fork
          src(2'h0, 2, 8'hC5);
          out(8'h80, 0, 8'h00);
        join
        cmp("queues", 10'h000, 10'(q_rx.size() + q_tx.size()));
        cmp("events", 10'h029, {4'h0, 2'(n_stall), 2'(n_nak),
          2'(n_ovs)});
        cmp("strap", {7'h04, uepl_pkg::START_APP}, {3'h0,
          FLEX_LINE_FOUR_OUT, FLEX_LINE_FIVE_OUT, STRAP_DONE_OUT,
          FLEX_LINE_FOUR_OE_OUT, FLEX_LINE_FIVE_OE_OUT,
          START_MODE_OUT});
      end
    join
    @(negedge CORE_CLK_IN);
    RST_N_IN = 1'b0;
    jump_five = 1'b1;
    {MEM_CORRUPT_IN, FLASH_MODE_IN, ENUM_FAIL_IN} = 3'h0;
    repeat (2) @(negedge CORE_CLK_IN);
    RST_N_IN = 1'b1;
    repeat (210) @(negedge CORE_CLK_IN);
    cmp("strap_five", {7'h04, uepl_pkg::START_FLASH}, {3'h0,
      FLEX_LINE_FOUR_OUT, FLEX_LINE_FIVE_OUT, STRAP_DONE_OUT,
      FLEX_LINE_FOUR_OE_OUT, FLEX_LINE_FIVE_OE_OUT,
      START_MODE_OUT});
    cmp("led_reset", 10'h200, {STATUS_LED_OUT, 9'h000});
    finish_test();
  end
endmodule
